// ==== rsi_pkg.sv ====
// Shared constants, types and segment decoding for the rpm shift indicator
package rsi_pkg;
	localparam int CLK_NS = 25; // Clock period
	localparam int US_NS = 1000; // One microsecond
	localparam int US_CYC = US_NS / CLK_NS; // Clocks per microsecond tick
	localparam int DEAD_S = 16; // Dead ignition time in seconds
	localparam int LAMP_MS = 1000; // Lamp test step in milliseconds
	localparam int FLASH_MS = 250; // Flash half period in milliseconds
	localparam int DEBOUNCE_MS = 20; // Button settle time in milliseconds
	localparam int US_PER_MS = 1000; // Microseconds per millisecond
	localparam int US_PER_S = 1000000; // Microseconds per second
	localparam int TW = 24; // Width of microsecond timers
	// Conversion constants: 60e6 / fires per rev / 100
	localparam logic [18:0] CNV_E8 = 19'h249f0; // Eight cylinders
	localparam logic [18:0] CNV_E4 = 19'h493e0; // Four cylinders
	localparam logic [18:0] CNV_E6 = 19'h30d40; // Six cylinders
	localparam logic [6:0] RPM_HI = 7'h5a; // 9000 rpm in hundreds
	localparam logic [6:0] RPM_LO = 7'h05; // 500 rpm in hundreds
	localparam logic [6:0] WARN_OFS = 7'h05; // 500 rpm above shift point
	localparam logic [3:0] THOU_DEF = 4'h6; // Default thousands digit
	localparam logic [3:0] THOU_MIN = 4'h1; // Lowest thousands digit
	localparam logic [3:0] THOU_MAX = 4'h7; // Highest thousands digit
	localparam logic [3:0] HUND_DEF = 4'h0; // Default hundreds digit
	localparam logic [3:0] HUND_MAX = 4'h9; // Highest hundreds digit
	localparam logic [15:0] IVL_MAX = 16'hffff; // Interval counter top
	// Segment patterns, active low, bit 6 is segment g
	localparam logic [6:0] SEG_BLANK = 7'h7f; // All off
	localparam logic [6:0] SEG_ALL = 7'h00; // All on
	localparam logic [6:0] SEG_DASH = 7'h3f; // Middle bar only
	localparam logic [6:0] SEG_E = 7'h06; // Letter E

	typedef enum logic [1:0] {ENG_E8, ENG_E4, ENG_E6} rsi_eng_e; // Engine options
	typedef struct packed {
		logic [6:0] hi; // Left digit segments
		logic [6:0] lo; // Right digit segments
	} rsi_disp_s;

	// Decimal digit to active-low segment pattern
	function automatic logic [6:0] rsi_seg(input logic [3:0] d);
		case (d)
			4'h0: rsi_seg = 7'h40;
			4'h1: rsi_seg = 7'h79;
			4'h2: rsi_seg = 7'h24;
			4'h3: rsi_seg = 7'h30;
			4'h4: rsi_seg = 7'h19;
			4'h5: rsi_seg = 7'h12;
			4'h6: rsi_seg = 7'h02;
			4'h7: rsi_seg = 7'h78;
			4'h8: rsi_seg = 7'h00;
			4'h9: rsi_seg = 7'h10;
			default: rsi_seg = 7'h7f;
		endcase
	endfunction
endpackage

// ==== rsi_debounce.sv ====
// Push button debouncer producing a one-cycle press pulse
`timescale 1ns/1ps
module rsi_debounce #(
	parameter int P_US = 20000 // Settle time in microseconds
) (
	input wire logic i_mclk, // System clock
	input wire logic i_rst_b, // Asynchronous reset, active low
	input wire logic i_tick, // Microsecond tick
	input wire logic i_raw, // Raw button level, high when pressed
	output logic o_press // One-cycle pulse per accepted press
);
	logic [15:0] cnt_r; // Stable time counter
	logic raw_r; // Last sampled level
	logic stable_r; // Accepted level

	// Restart settle time whenever the raw level moves
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			raw_r <= 1'b0;
			cnt_r <= 16'h0000;
		end else begin
			raw_r <= i_raw;
			if (raw_r != i_raw) begin
				cnt_r <= 16'h0000;
			end else if (i_tick && cnt_r != P_US[15:0]) begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// Accept the level once it held for the settle time
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stable_r <= 1'b0;
			o_press <= 1'b0;
		end else begin
			o_press <= 1'b0;
			if (cnt_r == P_US[15:0] && stable_r != raw_r) begin
				stable_r <= raw_r;
				o_press <= raw_r;
			end
		end
	end
endmodule // rsi_debounce

// ==== rsi_rpm_div.sv ====
// Sequential restoring divider turning an interval into rpm in hundreds
`timescale 1ns/1ps
module rsi_rpm_div (
	input wire logic i_mclk, // System clock
	input wire logic i_rst_b, // Asynchronous reset, active low
	input wire logic i_start, // Start pulse, ignored while busy
	input wire logic [18:0] i_dividend, // Conversion constant
	input wire logic [15:0] i_divisor, // Interval in microseconds, nonzero
	output logic o_busy, // Division in progress
	output logic o_done, // One-cycle pulse with a fresh quotient
	output logic [18:0] o_quot // Quotient, held until next done
);
	logic [18:0] dvd_r; // Dividend shifting into quotient
	logic [15:0] rem_r; // Partial remainder
	logic [4:0] cnt_r; // Bits left
	logic [16:0] trial; // Remainder with next dividend bit
	logic fits; // Divisor fits into trial

	// One quotient bit per clock
	always_comb begin
		trial = {rem_r, dvd_r[18]};
		fits = trial >= {1'b0, i_divisor};
	end

	// Shift-subtract loop
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dvd_r <= 19'h00000;
			rem_r <= 16'h0000;
			cnt_r <= 5'h00;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_quot <= 19'h00000;
		end else begin
			o_done <= 1'b0;
			if (!o_busy) begin
				if (i_start) begin
					dvd_r <= i_dividend;
					rem_r <= 16'h0000;
					cnt_r <= 5'h13;
					o_busy <= 1'b1;
				end
			end else begin
				rem_r <= fits ? 16'(trial - {1'b0, i_divisor}) : trial[15:0];
				dvd_r <= {dvd_r[17:0], fits};
				cnt_r <= cnt_r - 5'h01;
				if (cnt_r == 5'h01) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					o_quot <= {dvd_r[17:0], fits};
				end
			end
		end
	end
endmodule // rsi_rpm_div

// ==== rsi_top.sv ====
// Rpm shift indicator: ignition timing, menu, display and shift lamp
`timescale 1ns/1ps
module rsi_top #(
	parameter int P_DEAD_US = rsi_pkg::DEAD_S * rsi_pkg::US_PER_S, // Dead ignition time
	parameter int P_LAMP_US = rsi_pkg::LAMP_MS * rsi_pkg::US_PER_MS, // Lamp test step
	parameter int P_FLASH_US = rsi_pkg::FLASH_MS * rsi_pkg::US_PER_MS, // Flash half period
	parameter int P_DEB_US = rsi_pkg::DEBOUNCE_MS * rsi_pkg::US_PER_MS // Button settle
) (
	input wire logic i_mclk, // 40 MHz system clock
	input wire logic i_rst_b, // Power-on reset, active low
	input wire logic i_ign, // Ignition pulse, high active
	input wire logic i_mode_btn, // Mode button, high when pressed
	input wire logic i_sel_btn, // Select button, high when pressed
	output rsi_pkg::rsi_disp_s o_disp, // Two digits, active-low segments
	output logic o_shift // Shift lamp, high lights it
);
	typedef enum logic [2:0] {
		ST_LAMP_HI, ST_LAMP_LO, ST_LAMP_SH, ST_CFG_ENG, ST_CFG_THOU, ST_CFG_HUND, ST_RUN
	} rsi_state_e;

	rsi_state_e state_r; // Menu state
	logic [5:0] us_cnt_r; // Microsecond prescaler
	logic us_tick; // One-cycle microsecond enable
	logic [1:0] press; // Debounced presses: 1 mode, 0 select
	logic mode_p; // Mode press pulse
	logic sel_p; // Select press pulse
	logic [rsi_pkg::TW-1:0] lamp_cnt_r; // Lamp test step timer
	logic lamp_done; // Lamp step elapsed
	rsi_pkg::rsi_eng_e eng_r; // Stored engine code
	logic [3:0] thou_r; // Shift point thousands
	logic [3:0] hund_r; // Shift point hundreds
	logic ign_r; // Last ignition level
	logic ign_rise; // Rising ignition edge
	logic act_r; // Timing cycle active
	logic [15:0] ivl_r; // Microseconds in current cycle
	logic slow_r; // Overflow abort pulse
	logic div_start_r; // Divider start pulse
	logic [15:0] div_ivl_r; // Recorded interval
	logic div_busy; // Divider busy
	logic div_done; // Divider result pulse
	logic [18:0] quot; // Divider quotient
	logic [18:0] cnv; // Conversion constant for engine
	logic [6:0] rpm_r; // Latest rpm in hundreds, saturated
	logic have_r; // A result exists since run began
	logic [rsi_pkg::TW-1:0] dead_cnt_r; // Time since last ignition edge
	logic dead_r; // Ignition declared dead
	logic [rsi_pkg::TW-1:0] fl_cnt_r; // Flash timer
	logic flash_r; // Flash phase, high shows
	logic [6:0] sp; // Shift point in hundreds
	logic out_rng; // Rpm beyond operating limits
	rsi_pkg::rsi_disp_s disp_nxt; // Next display
	logic shift_nxt; // Next lamp

	assign mode_p = press[1];
	assign sel_p = press[0];
	assign sp = {3'h0, thou_r} * 7'h0a + {3'h0, hund_r}; // Widened first so the product is not cut
	assign out_rng = rpm_r > rsi_pkg::RPM_HI || rpm_r < rsi_pkg::RPM_LO;
	assign lamp_done = us_tick && lamp_cnt_r == rsi_pkg::TW'(P_LAMP_US - 1);
	assign us_tick = us_cnt_r == 6'(rsi_pkg::US_CYC - 1);
	assign ign_rise = i_ign && !ign_r;

	// Microsecond prescaler
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			us_cnt_r <= 6'h00;
		end else begin
			us_cnt_r <= us_tick ? 6'h00 : us_cnt_r + 6'h01;
		end
	end

	// Debounce both buttons
	generate
		for (genvar g = 0; g < 2; g++) begin : g_btn
			rsi_debounce #(.P_US(P_DEB_US)) u_deb (
				.i_mclk(i_mclk),
				.i_rst_b(i_rst_b),
				.i_tick(us_tick),
				.i_raw(g == 1 ? i_mode_btn : i_sel_btn),
				.o_press(press[g])
			);
		end
	endgenerate

	// Lamp test step timer, restarts each step
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lamp_cnt_r <= '0;
		end else if (lamp_done) begin
			lamp_cnt_r <= '0;
		end else if (us_tick) begin
			lamp_cnt_r <= lamp_cnt_r + rsi_pkg::TW'(1);
		end
	end

	// Menu state machine
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= ST_LAMP_HI;
		end else begin
			unique case (state_r)
				ST_LAMP_HI: if (lamp_done) state_r <= ST_LAMP_LO;
				ST_LAMP_LO: if (lamp_done) state_r <= ST_LAMP_SH;
				ST_LAMP_SH: if (lamp_done) state_r <= ST_CFG_ENG;
				ST_CFG_ENG: if (mode_p) state_r <= ST_CFG_THOU;
				ST_CFG_THOU: if (mode_p) state_r <= ST_CFG_HUND;
				ST_CFG_HUND: if (mode_p) state_r <= ST_RUN;
				ST_RUN: if (mode_p) state_r <= ST_CFG_ENG;
			endcase
		end
	end

	// Settings, changed only by Select in their own menu step
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			eng_r <= rsi_pkg::ENG_E8;
			thou_r <= rsi_pkg::THOU_DEF;
			hund_r <= rsi_pkg::HUND_DEF;
		end else if (sel_p) begin
			unique case (state_r)
				ST_CFG_ENG: begin
					unique case (eng_r)
						rsi_pkg::ENG_E8: eng_r <= rsi_pkg::ENG_E4;
						rsi_pkg::ENG_E4: eng_r <= rsi_pkg::ENG_E6;
						default: eng_r <= rsi_pkg::ENG_E8;
					endcase
				end
				ST_CFG_THOU: begin
					thou_r <= thou_r >= rsi_pkg::THOU_MAX ? rsi_pkg::THOU_MIN : thou_r + 4'h1;
				end
				ST_CFG_HUND: begin
					hund_r <= hund_r >= rsi_pkg::HUND_MAX ? 4'h0 : hund_r + 4'h1;
				end
				default: begin // Select outside the setting steps leaves values alone
				end
			endcase
		end
	end

	// Ignition timing: alternate edges start and end a cycle
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ign_r <= 1'b0;
			act_r <= 1'b0;
			ivl_r <= 16'h0000;
			slow_r <= 1'b0;
			div_start_r <= 1'b0;
			div_ivl_r <= 16'h0001;
		end else begin
			ign_r <= i_ign;
			slow_r <= 1'b0;
			div_start_r <= 1'b0;
			if (ign_rise) begin
				act_r <= !act_r;
				ivl_r <= 16'h0000;
				if (act_r && !div_busy) begin // Skip if last result not yet done
					div_start_r <= 1'b1;
					div_ivl_r <= ivl_r == 16'h0000 ? 16'h0001 : ivl_r;
				end
			end else if (act_r && us_tick) begin
				if (ivl_r == rsi_pkg::IVL_MAX) begin
					act_r <= 1'b0;
					slow_r <= 1'b1;
				end else begin
					ivl_r <= ivl_r + 16'h0001;
				end
			end
		end
	end

	// Constant picks the multiplier 15, 30 or 20 per cylinder count
	always_comb begin
		unique case (eng_r)
			rsi_pkg::ENG_E4: cnv = rsi_pkg::CNV_E4;
			rsi_pkg::ENG_E6: cnv = rsi_pkg::CNV_E6;
			default: cnv = rsi_pkg::CNV_E8;
		endcase
	end

	rsi_rpm_div u_div (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_start(div_start_r),
		.i_dividend(cnv),
		.i_divisor(div_ivl_r),
		.o_busy(div_busy),
		.o_done(div_done),
		.o_quot(quot)
	);

	// Latest result; valid flag held clear outside run so display starts blank
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rpm_r <= 7'h00;
			have_r <= 1'b0;
		end else if (state_r != ST_RUN) begin
			have_r <= 1'b0;
		end else if (div_done) begin
			rpm_r <= quot > 19'h0007f ? 7'h7f : quot[6:0];
			have_r <= 1'b1;
		end else if (slow_r) begin
			rpm_r <= 7'h00; // Too slow reads as below range
			have_r <= 1'b1;
		end
	end

	// Dead ignition watchdog
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dead_cnt_r <= '0;
			dead_r <= 1'b0;
		end else if (ign_rise || state_r != ST_RUN) begin
			dead_cnt_r <= '0;
			dead_r <= 1'b0;
		end else if (us_tick && !dead_r) begin
			if (dead_cnt_r == rsi_pkg::TW'(P_DEAD_US - 1)) begin
				dead_r <= 1'b1;
			end
			dead_cnt_r <= dead_cnt_r + rsi_pkg::TW'(1);
		end
	end

	// Flash phase for menu digits and warning lamp
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fl_cnt_r <= '0;
			flash_r <= 1'b1;
		end else if (us_tick) begin
			if (fl_cnt_r == rsi_pkg::TW'(P_FLASH_US - 1)) begin
				fl_cnt_r <= '0;
				flash_r <= !flash_r;
			end else begin
				fl_cnt_r <= fl_cnt_r + rsi_pkg::TW'(1);
			end
		end
	end

	// Display and lamp selection
	always_comb begin
		disp_nxt.hi = rsi_pkg::SEG_BLANK;
		disp_nxt.lo = rsi_pkg::SEG_BLANK;
		shift_nxt = 1'b0;
		unique case (state_r)
			ST_LAMP_HI: disp_nxt.hi = rsi_pkg::SEG_ALL;
			ST_LAMP_LO: disp_nxt.lo = rsi_pkg::SEG_ALL;
			ST_LAMP_SH: shift_nxt = 1'b1;
			ST_CFG_ENG: begin
				disp_nxt.hi = rsi_pkg::SEG_E;
				unique case (eng_r)
					rsi_pkg::ENG_E4: disp_nxt.lo = rsi_pkg::rsi_seg(4'h4);
					rsi_pkg::ENG_E6: disp_nxt.lo = rsi_pkg::rsi_seg(4'h6);
					default: disp_nxt.lo = rsi_pkg::rsi_seg(4'h8);
				endcase
				if (!flash_r) disp_nxt.lo = rsi_pkg::SEG_BLANK;
			end
			ST_CFG_THOU, ST_CFG_HUND: begin
				disp_nxt.hi = rsi_pkg::rsi_seg(thou_r);
				disp_nxt.lo = rsi_pkg::rsi_seg(hund_r);
				if (!flash_r && state_r == ST_CFG_THOU) disp_nxt.hi = rsi_pkg::SEG_BLANK;
				if (!flash_r && state_r == ST_CFG_HUND) disp_nxt.lo = rsi_pkg::SEG_BLANK;
			end
			ST_RUN: begin
				if (dead_r || (have_r && out_rng)) begin
					disp_nxt.hi = rsi_pkg::SEG_DASH;
					disp_nxt.lo = rsi_pkg::SEG_DASH;
				end else if (have_r) begin
					disp_nxt.hi = rsi_pkg::rsi_seg(4'(rpm_r / 7'h0a));
					disp_nxt.lo = rsi_pkg::rsi_seg(4'(rpm_r % 7'h0a));
					if (rpm_r >= 7'(sp + rsi_pkg::WARN_OFS)) begin
						shift_nxt = flash_r;
					end else if (rpm_r >= sp) begin
						shift_nxt = 1'b1;
					end
				end
			end
		endcase
	end

	// Registered outputs
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_disp <= {rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK};
			o_shift <= 1'b0;
		end else begin
			o_disp <= disp_nxt;
			o_shift <= shift_nxt;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	a_lamp_shift_on: assert property (
		state_r == ST_LAMP_SH |=> o_shift && o_disp == {rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK})
		else $error("shift lamp not lit in lamp test");
	a_cfg_after_lamp: assert property (
		state_r == ST_LAMP_SH && lamp_done |=> state_r == ST_CFG_ENG ##1 o_disp.hi == rsi_pkg::SEG_E)
		else $error("configuration not entered after lamp test");
	a_eng_code_cycle: assert property (
		state_r == ST_CFG_ENG && sel_p && eng_r == rsi_pkg::ENG_E6 |=> eng_r == rsi_pkg::ENG_E8)
		else $error("engine code did not wrap to eight");
	a_thou_wrap: assert property (
		state_r == ST_CFG_THOU && sel_p && thou_r == rsi_pkg::THOU_MAX |=> thou_r == rsi_pkg::THOU_MIN)
		else $error("thousands digit did not wrap to one");
	a_hund_wrap: assert property (
		state_r == ST_CFG_HUND && sel_p && hund_r == rsi_pkg::HUND_MAX |=> hund_r == 4'h0)
		else $error("hundreds digit did not wrap to zero");
	a_run_blank: assert property (
		state_r == ST_CFG_HUND && mode_p |=> state_r == ST_RUN ##1
		o_disp == {rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK})
		else $error("run did not start blank");
	a_mode_keeps_sp: assert property (
		state_r != ST_RUN && mode_p && !sel_p |=> $stable(thou_r) && $stable(hund_r))
		else $error("shift point changed on mode press");
	a_dead_dashes: assert property (
		state_r == ST_RUN && dead_r && !mode_p |=> o_disp == {rsi_pkg::SEG_DASH, rsi_pkg::SEG_DASH})
		else $error("dead ignition not shown as dashes");
	a_range_dashes: assert property (
		state_r == ST_RUN && have_r && out_rng && !mode_p |=> o_disp.hi == rsi_pkg::SEG_DASH && !o_shift)
		else $error("out of range speed not shown as dashes");
	a_shift_steady: assert property (
		state_r == ST_RUN && have_r && !dead_r && !out_rng && rpm_r >= sp
		&& rpm_r < 7'(sp + rsi_pkg::WARN_OFS) && !mode_p |=> o_shift)
		else $error("shift lamp not steady at shift point");
	a_shift_warn: assert property (
		state_r == ST_RUN && have_r && !dead_r && !out_rng
		&& rpm_r >= 7'(sp + rsi_pkg::WARN_OFS) && !mode_p |=> o_shift == $past(flash_r))
		else $error("shift lamp not flashing above warning point");
	a_ovf_abort: assert property (
		act_r && us_tick && ivl_r == rsi_pkg::IVL_MAX && !ign_rise |=> !act_r && slow_r)
		else $error("interval overflow did not abort");
endmodule // rsi_top

// ==== rsi_partner.sv ====
// Model of the outside world: ignition pickup and the two push buttons
`timescale 1ns/1ps
module rsi_partner #(
	parameter int P_DEB_US = 5 // Button settle time used by the device
) (
	input wire logic i_mclk, // System clock
	output logic o_ign, // Ignition pulse, high active
	output logic o_mode_btn, // Mode button level, high when pressed
	output logic o_sel_btn // Select button level, high when pressed
);
	localparam int US = rsi_pkg::US_CYC; // Clocks per microsecond

	// Idle levels: no spark, both buttons released
	initial begin
		o_ign = 1'b0;
		o_mode_btn = 1'b0;
		o_sel_btn = 1'b0;
	end

	// Let a number of microseconds pass
	task automatic wait_us(input int n);
		repeat (n * US) @(posedge i_mclk);
	endtask

	// Press and release Mode, each level held one microsecond past settling
	task automatic press_mode();
		@(posedge i_mclk);
		o_mode_btn <= 1'b1;
		wait_us(P_DEB_US + 1);
		o_mode_btn <= 1'b0;
		wait_us(P_DEB_US + 1);
	endtask

	// Press and release Select, same timing as Mode
	task automatic press_sel();
		@(posedge i_mclk);
		o_sel_btn <= 1'b1;
		wait_us(P_DEB_US + 1);
		o_sel_btn <= 1'b0;
		wait_us(P_DEB_US + 1);
	endtask

	// One rising ignition edge with a short high phase, like a real pickup
	task automatic fire();
		o_ign <= 1'b1;
		repeat (20) @(posedge i_mclk);
		o_ign <= 1'b0;
	endtask

	// Two rising edges spaced by a whole number of microseconds
	task automatic ign_pair(input int us);
		@(posedge i_mclk);
		fire();
		repeat (us * US - 20) @(posedge i_mclk);
		fire();
		wait_us(2);
	endtask
endmodule // rsi_partner

// ==== tb_top.sv ====
// Self-checking testbench for the rpm shift indicator
`timescale 1ns/1ps
module tb_top;
	localparam int US = rsi_pkg::US_CYC; // Clocks per microsecond
	localparam int CHK = 7 * US; // Watch window, longer than one flash half period
	localparam int IVL_OK = 1797; // Interval giving 83 hundred rpm on eight cylinders
	localparam int IVL_HI = 100; // Interval far above the upper speed limit
	localparam logic [6:0] SEG_D [10] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19,
		7'h12, 7'h02, 7'h78, 7'h00, 7'h10}; // Digit patterns, active low
	localparam int ENG_D [3] = '{4, 6, 8}; // Engine codes in Select order

	logic i_mclk; // System clock
	logic i_rst_b; // Reset, active low
	logic ign; // Ignition from the model
	logic mode_btn; // Mode button from the model
	logic sel_btn; // Select button from the model
	rsi_pkg::rsi_disp_s o_disp; // Display segments
	logic o_shift; // Shift lamp
	int fail_count; // Mismatches seen
	int n_checks; // Comparisons made

	// Device with shortened timers
	rsi_top #(
		.P_DEAD_US(60),
		.P_LAMP_US(20),
		.P_FLASH_US(5),
		.P_DEB_US(5)
	) i_rsi_top (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_ign(ign),
		.i_mode_btn(mode_btn),
		.i_sel_btn(sel_btn),
		.o_disp(o_disp),
		.o_shift(o_shift)
	);

	// Ignition pickup and buttons; its default settle time matches the device's
	rsi_partner i_rsi_partner (
		.i_mclk(i_mclk),
		.o_ign(ign),
		.o_mode_btn(mode_btn),
		.o_sel_btn(sel_btn)
	);

	// 40 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// Let a number of clocks pass
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// Watch display and lamp for n clocks; a flashing digit must show both value and blank
	task automatic chk_disp(input logic [6:0] hi, input logic [6:0] lo, input logic fh,
		input logic fl, input logic sh, input int n);
		int bad;
		int nh;
		int nl;
		logic bh;
		logic bl;
		bad = 0;
		nh = 0;
		nl = 0;
		bh = 1'b0;
		bl = 1'b0;
		repeat (n) begin
			@(negedge i_mclk);
			if (o_disp.hi === hi) begin
				nh++;
			end else if (fh && o_disp.hi === rsi_pkg::SEG_BLANK) begin
				bh = 1'b1;
			end else begin
				bad++;
			end
			if (o_disp.lo === lo) begin
				nl++;
			end else if (fl && o_disp.lo === rsi_pkg::SEG_BLANK) begin
				bl = 1'b1;
			end else begin
				bad++;
			end
			if (o_shift !== sh) begin
				bad++;
			end
		end
		n_checks++;
		if (bad != 0 || nh == 0 || nl == 0 || bh !== fh || bl !== fl) begin
			fail_count++;
			$display("ERROR %0t: display not %h/%h lamp %b", $time, hi, lo, sh);
		end
	endtask

	// Power-up lamp test: left digit, right digit, then lamp
	task automatic t_lamp_test();
		wait_clk(2 * US);
		chk_disp(rsi_pkg::SEG_ALL, rsi_pkg::SEG_BLANK, 0, 0, 0, 15 * US);
		wait_clk(5 * US);
		chk_disp(rsi_pkg::SEG_BLANK, rsi_pkg::SEG_ALL, 0, 0, 0, 15 * US);
		wait_clk(5 * US);
		chk_disp(rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK, 0, 0, 1, 15 * US);
		wait_clk(5 * US);
	endtask

	// Engine code menu: default then the full Select cycle
	task automatic t_engine_code();
		chk_disp(rsi_pkg::SEG_E, SEG_D[8], 0, 1, 0, CHK);
		for (int k = 0; k < 3; k++) begin
			i_rsi_partner.press_sel();
			chk_disp(rsi_pkg::SEG_E, SEG_D[ENG_D[k]], 0, 1, 0, CHK);
		end
	endtask

	// Shift point menu: default, thousands wrap, hundreds up to nine
	task automatic t_shift_point();
		i_rsi_partner.press_mode();
		chk_disp(SEG_D[6], SEG_D[0], 1, 0, 0, CHK);
		i_rsi_partner.press_sel();
		chk_disp(SEG_D[7], SEG_D[0], 1, 0, 0, CHK);
		i_rsi_partner.press_sel();
		chk_disp(SEG_D[1], SEG_D[0], 1, 0, 0, CHK);
		repeat (6) i_rsi_partner.press_sel();
		i_rsi_partner.press_mode();
		chk_disp(SEG_D[7], SEG_D[0], 0, 1, 0, CHK);
		repeat (9) i_rsi_partner.press_sel();
		chk_disp(SEG_D[7], SEG_D[9], 0, 1, 0, CHK);
	endtask

	// Run: blank, dead ignition, in-range reading with lamp, over-range reading
	task automatic t_run();
		i_rsi_partner.press_mode();
		chk_disp(rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK, 0, 0, 0, CHK);
		wait_clk(50 * US);
		chk_disp(rsi_pkg::SEG_DASH, rsi_pkg::SEG_DASH, 0, 0, 0, CHK);
		i_rsi_partner.ign_pair(IVL_OK);
		chk_disp(SEG_D[8], SEG_D[3], 0, 0, 1, CHK);
		i_rsi_partner.ign_pair(IVL_HI);
		chk_disp(rsi_pkg::SEG_DASH, rsi_pkg::SEG_DASH, 0, 0, 0, CHK);
	endtask

	// Back to the menu and through it with Mode alone
	task automatic t_return();
		i_rsi_partner.press_mode();
		chk_disp(rsi_pkg::SEG_E, SEG_D[8], 0, 1, 0, CHK);
		i_rsi_partner.press_mode();
		chk_disp(SEG_D[7], SEG_D[9], 1, 0, 0, CHK);
		repeat (2) i_rsi_partner.press_mode();
		chk_disp(rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK, 0, 0, 0, CHK);
	endtask

	// Print counts and verdict, then stop
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence: reset, then the scenarios in menu order
	initial begin
		fail_count = 0;
		n_checks = 0;
		i_rst_b = 1'b0;
		chk_disp(rsi_pkg::SEG_BLANK, rsi_pkg::SEG_BLANK, 0, 0, 0, 1);
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		t_lamp_test();
		t_engine_code();
		t_shift_point();
		t_run();
		t_return();
		wrap_up();
	end

	// Watchdog: the scenarios need about 98000 clocks
	initial begin
		repeat (105000) @(posedge i_mclk);
		fail_count++;
		$display("ERROR %0t: run did not finish in time", $time);
		wrap_up();
	end
endmodule // tb_top
